// ===== bit_sampler.sv
// controller model taking received bits off the data pin
// assumes bit clock, data and enable straight from the back end
`default_nettype none
module bit_sampler (
    input  wire logic        bit_clock_in,
    input  wire logic        data_in,
    input  wire logic        oe_in,
    output var logic  [15:0] window_out,
    output var int           count_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial window_out = 16'h0000;
    initial count_out = 0;
    // falling edge is mid-bit, away from the device's data change
    always @(negedge bit_clock_in) begin
        if (oe_in) begin
            window_out <= {window_out[14:0], data_in};
            count_out  <= count_out + 1;
        end
    end
endmodule : bit_sampler
`default_nettype wire

// ===== rx_backend_cfg.svh
// constants of the receive back end: register offsets, fields, resets, timing
// assumes inclusion by its bare name from the design file
`ifndef RX_BACKEND_CFG_SVH
`define RX_BACKEND_CFG_SVH
`define ADDR_CLOCK_SELECT_A    7'h06
`define ADDR_CLOCK_DIVIDER_B   7'h07
`define ADDR_FREQ_ERROR_CTRL   7'h15
`define ADDR_FREQ_ERROR_RESULT 7'h16
`define ADDR_RX_CONTROL        7'h00
`define SYNC_SCALE_MSB   3
`define SYNC_SCALE_LSB   1
`define RATE_SCALE_HI    0
`define RATE_SCALE_MSB   7
`define RATE_SCALE_LSB   6
`define REF_DIV_MSB      5
`define REF_DIV_LSB      0
`define MOD_SCALE_MSB    6
`define MOD_SCALE_LSB    4
`define SYNC_EN_BIT      3
`define RX_MODE_MSB      2
`define RX_MODE_LSB      1
`define RX_MODE_RECEIVE  2'h1
`define EST_MODE_MSB     1
`define EST_MODE_LSB     0
`define EST_SPAN_MSB     3
`define EST_SPAN_LSB     2
`define RESET_CLOCK_A    8'h00
`define RESET_CLOCK_B    8'h01
`define RESET_EST_CTRL   8'h00
`define RESET_RX_CTRL    8'h00
`define OVERSAMPLE       16
`define SCALE_TOP        7
`endif

// ===== rx_backend_monitor.sv
// port checker of the receive back end, bound to its top module
// assumes one clock domain and the register map of the back end
`default_nettype none
module rx_backend_monitor (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       rx_bit_in,
    input wire logic       recovered_bit_clock_out,
    input wire logic       serial_data_pin_out,
    input wire logic       serial_data_pin_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ctrl_q, rxc_q;
    logic [2:0] sc_q, stab_q;
    logic [5:0] rf_q;
    logic [4:0] rise_q;
    logic       clk_q;
    wire logic  cfg_wr  = wr_in && (addr_in == 7'h00 || addr_in[6:1] == 6'h03);
    wire logic  sync_on = rxc_q[3] && rxc_q[2:1] == 2'h1;
    wire logic  fast    = sc_q == 3'h7 && rf_q == 6'h01;
    wire logic  rise    = recovered_bit_clock_out && !clk_q && rise_q != 5'h1f;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_q <= 4'h0;
            rxc_q  <= 4'h0;
            sc_q   <= 3'h0;
            rf_q   <= 6'h01;
        end else if (wr_in) begin
            if (addr_in == 7'h15) ctrl_q <= wdata_in[3:0];
            if (addr_in == 7'h00) rxc_q <= wdata_in[3:0];
            if (addr_in == 7'h06) sc_q <= wdata_in[3:1];
            if (addr_in == 7'h07) rf_q <= wdata_in[5:0];
        end
    end
    // settle time after a mode change, lock time before the clock shape holds
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stab_q <= 3'h0;
            rise_q <= 5'h00;
            clk_q  <= 1'b0;
        end else begin
            clk_q  <= recovered_bit_clock_out;
            stab_q <= cfg_wr ? 3'h0 : stab_q + {2'h0, stab_q != 3'h7};
            rise_q <= cfg_wr ? 5'h00 : rise_q + {4'h0, rise};
        end
    end
    sequence s_high; recovered_bit_clock_out [*7]; endsequence
    sequence s_low; !recovered_bit_clock_out [*8] ##1 !recovered_bit_clock_out; endsequence
    property p_idle_read; !rd_in |=> rdata_out == 8'h00; endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data outside slot");
    property p_unmapped; rd_in && addr_in == 7'h40 |=> rdata_out == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_clka_top; rd_in && addr_in == 7'h06 |=> !rdata_out[7]; endproperty
    a_clka_top: assert property (p_clka_top) else $error("clock select top bit set");
    property p_ctrl_back; rd_in && addr_in == 7'h15 |=> rdata_out[3:0] == ctrl_q; endproperty
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback");
    property p_oe_rx; stab_q == 3'h7 |-> serial_data_pin_oe_out == (rxc_q[2:1] == 2'h1); endproperty
    a_oe_rx: assert property (p_oe_rx) else $error("data enable vs mode");
    property p_clk_off; stab_q == 3'h7 && !sync_on |-> !recovered_bit_clock_out; endproperty
    a_clk_off: assert property (p_clk_off) else $error("bit clock outside sync");
    property p_follow; stab_q == 3'h7 && !sync_on |=> serial_data_pin_out == $past(rx_bit_in);
    endproperty
    a_follow: assert property (p_follow) else $error("data pin not following");
    property p_data_rise;
        stab_q == 3'h7 && sync_on && $changed(serial_data_pin_out)
            |-> $rose(recovered_bit_clock_out);
    endproperty
    a_data_rise: assert property (p_data_rise) else $error("data moved off rise");
    property p_clk_shape;
        fast && sync_on && rise_q == 5'h1f && $rose(recovered_bit_clock_out)
            |-> s_high ##1 s_low ##1 recovered_bit_clock_out;
    endproperty
    a_clk_shape: assert property (p_clk_shape) else $error("bit clock shape");
endmodule : rx_backend_monitor
bind rx_freq_error_and_bit_sync rx_backend_monitor i_mon (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_bit_in(rx_bit_in),
    .recovered_bit_clock_out(recovered_bit_clock_out),
    .serial_data_pin_out(serial_data_pin_out),
    .serial_data_pin_oe_out(serial_data_pin_oe_out)
);
`default_nettype wire

// ===== rx_backend_pkg.sv
// types of the receive back end
// assumes the cfg header sits in the same folder
`default_nettype none
package rx_backend_pkg;
    typedef enum logic [1:0] {est_off, est_up, est_down, est_both} est_mode_e;
    typedef enum logic [1:0] {sync_idle, sync_hunt, sync_locked} sync_state_e;
endpackage : rx_backend_pkg
`default_nettype wire

// ===== rx_freq_error_and_bit_sync.sv
// frequency error estimator, bit synchronizer, output fifo and register port
// assumes demodulator pulses and bit stream synchronous to clk_in
//
// Implementation choice: the strobed register port.
`include "rx_backend_cfg.svh"
`default_nettype none

module stream_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             clear_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    // one bit wider than the pointers so full and empty never alias
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_q != '0);
    assign rd_data_out  = mem_q[rp_q];
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (clear_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : stream_fifo

module rx_freq_error_and_bit_sync #(
    parameter int FIFO_DEPTH = 8,
    parameter int CNT_W      = 12
) (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic [6:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       up_pulse_in,
    input  wire logic       down_pulse_in,
    input  wire logic       rx_bit_in,
    output logic            recovered_bit_clock_out,
    output logic            serial_data_pin_out,
    output logic            serial_data_pin_oe_out,
    output logic            modulator_tick_out,
    output logic            rate_tick_out
);
    import rx_backend_pkg::*;

    logic [7:0] clock_a_q;
    logic [7:0] clock_b_q;
    logic [7:0] est_ctrl_q;
    logic [7:0] rx_ctrl_q;
    logic [7:0] result_q;
    logic [7:0] rdata_q;

    // register writes
    // the result register has no write path, writes to it fall through
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clock_a_q  <= `RESET_CLOCK_A;
            clock_b_q  <= `RESET_CLOCK_B;
            est_ctrl_q <= `RESET_EST_CTRL;
            rx_ctrl_q  <= `RESET_RX_CTRL;
        end else if (wr_in) begin
            if (addr_in == `ADDR_CLOCK_SELECT_A) begin
                clock_a_q <= {1'b0, wdata_in[6:0]};
            end else if (addr_in == `ADDR_CLOCK_DIVIDER_B) begin
                clock_b_q <= wdata_in;
            end else if (addr_in == `ADDR_FREQ_ERROR_CTRL) begin
                est_ctrl_q <= {4'h0, wdata_in[3:0]};
            end else if (addr_in == `ADDR_RX_CONTROL) begin
                rx_ctrl_q <= wdata_in;
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= 8'h00;
        end else if (!rd_in) begin
            rdata_q <= 8'h00;
        end else if (addr_in == `ADDR_CLOCK_SELECT_A) begin
            rdata_q <= clock_a_q;
        end else if (addr_in == `ADDR_CLOCK_DIVIDER_B) begin
            rdata_q <= clock_b_q;
        end else if (addr_in == `ADDR_FREQ_ERROR_CTRL) begin
            rdata_q <= est_ctrl_q;
        end else if (addr_in == `ADDR_FREQ_ERROR_RESULT) begin
            rdata_q <= result_q;
        end else if (addr_in == `ADDR_RX_CONTROL) begin
            rdata_q <= rx_ctrl_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata_out = rdata_q;

    // shared reference divider and power-of-two scalers
    logic [5:0] ref_div;
    logic [2:0] sync_scale;
    logic [2:0] rate_scale;
    logic [2:0] mod_scale;
    logic [5:0] ref_cnt_q;
    logic       ref_tick;
    logic [6:0] pre_cnt_q;
    assign ref_div    = clock_b_q[`REF_DIV_MSB:`REF_DIV_LSB];
    assign sync_scale = clock_a_q[`SYNC_SCALE_MSB:`SYNC_SCALE_LSB];
    assign rate_scale = {clock_a_q[`RATE_SCALE_HI],
                         clock_b_q[`RATE_SCALE_MSB:`RATE_SCALE_LSB]};
    assign mod_scale  = clock_a_q[`MOD_SCALE_MSB:`MOD_SCALE_LSB];
    // a zero divider is treated as one so the scalers never stall
    assign ref_tick   = (ref_cnt_q >= ref_div - 6'h01) || (ref_div == 6'h00);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_cnt_q <= 6'h00;
            pre_cnt_q <= 7'h00;
        end else if (ref_tick) begin
            ref_cnt_q <= 6'h00;
            pre_cnt_q <= pre_cnt_q + 7'h01;
        end else begin
            ref_cnt_q <= ref_cnt_q + 6'h01;
        end
    end

    // tick when the low (7 - scale) prescaler bits roll over
    function automatic logic scaled_tick(input logic [6:0] cnt, input logic [2:0] sc);
        logic [6:0] mask;
        mask = 7'h7f >> sc;
        return (cnt & mask) == mask;
    endfunction : scaled_tick

    logic sync_tick;
    assign sync_tick = ref_tick && scaled_tick(pre_cnt_q, sync_scale);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            modulator_tick_out <= 1'b0;
            rate_tick_out      <= 1'b0;
        end else begin
            modulator_tick_out <= ref_tick && scaled_tick(pre_cnt_q, mod_scale);
            rate_tick_out      <= ref_tick && scaled_tick(pre_cnt_q, rate_scale);
        end
    end

    // frequency error estimator
    est_mode_e  est_mode;
    logic [1:0] span_code;
    logic [6:0] span_len;
    logic [CNT_W-1:0] acc_q;
    logic [6:0] sym_cnt_q;
    logic       sym_done;
    logic [1:0] est_mode_q;
    assign est_mode  = est_mode_e'(est_ctrl_q[`EST_MODE_MSB:`EST_MODE_LSB]);
    assign span_code = est_ctrl_q[`EST_SPAN_MSB:`EST_SPAN_LSB];
    assign span_len  = 7'h08 << span_code;

    // own symbol framing, so spans complete with the synchronizer off too
    // framing restarts with the count so every span is exactly its length, except where a write changes only the span code
    logic [3:0] sym_tick_q;
    logic       est_restart;
    assign est_restart = est_mode == est_off || est_mode_q != est_mode;
    assign sym_done    = sync_tick && sym_tick_q == 4'hf;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sym_tick_q <= 4'h0;
        end else if (est_restart) begin
            sym_tick_q <= 4'h0;
        end else if (sync_tick) begin
            sym_tick_q <= sym_tick_q + 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_q      <= '0;
            sym_cnt_q  <= 7'h00;
            result_q   <= 8'h00;
            est_mode_q <= 2'h0;
        end else begin
            est_mode_q <= est_mode;
            if (est_restart) begin
                // a mode change restarts the span
                // off mode clears the count but keeps the last result
                acc_q     <= '0;
                sym_cnt_q <= 7'h00;
            end else begin
                if (sym_done && sym_cnt_q >= span_len - 7'h01) begin
                    // saturate into eight bits, wide count avoids wrap
                    result_q  <= sat8(acc_q);
                    acc_q     <= '0;
                    sym_cnt_q <= 7'h00;
                end else begin
                    if (sym_done) begin
                        sym_cnt_q <= sym_cnt_q + 7'h01;
                    end
                    case (est_mode)
                        est_up:   acc_q <= acc_q + CNT_W'(up_pulse_in);
                        est_down: acc_q <= acc_q - CNT_W'(down_pulse_in);
                        est_both: acc_q <= acc_q + CNT_W'(up_pulse_in)
                                         - CNT_W'(down_pulse_in);
                        default:  acc_q <= acc_q;
                    endcase
                end
            end
        end
    end

    function automatic logic [7:0] sat8(input logic [CNT_W-1:0] v);
        logic signed [CNT_W-1:0] s;
        s = $signed(v);
        if (s > 127) begin
            return 8'h7f;
        end else if (s < -128) begin
            return 8'h80;
        end
        return v[7:0];
    endfunction : sat8

    // bit synchronizer: 16 sync ticks per bit, phase nudged on data edges
    sync_state_e state_q;
    logic       sync_on;
    logic [3:0] phase_q;
    logic       prev_bit_q;
    logic [4:0] align_q;
    logic       fifo_ready;
    logic       fifo_valid;
    logic       fifo_bit;
    logic       take_bit;
    logic       push_bit;
    assign sync_on  = rx_ctrl_q[`SYNC_EN_BIT] &&
                      rx_ctrl_q[`RX_MODE_MSB:`RX_MODE_LSB] == `RX_MODE_RECEIVE;
    assign push_bit = sync_on && sync_tick && phase_q == 4'h7 &&
                      fifo_ready;
    assign take_bit = sync_on && sync_tick && phase_q == 4'h0;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q    <= sync_idle;
            phase_q    <= 4'h0;
            prev_bit_q <= 1'b0;
            align_q    <= 5'h00;
        end else if (!sync_on) begin
            state_q <= sync_idle;
            phase_q <= 4'h0;
            align_q <= 5'h00;
        end else if (sync_tick) begin
            prev_bit_q <= rx_bit_in;
            case (state_q)
                sync_idle: begin
                    state_q <= sync_hunt;
                    phase_q <= phase_q + 4'h1;
                end
                default: begin
                    // one phase step per data edge; a worst offset of eight steps
                    // needs eight edges, well inside 22 symbols
                    if (rx_bit_in != prev_bit_q && phase_q != 4'h0) begin
                        phase_q <= (phase_q < 4'h8) ? phase_q : phase_q + 4'h2;
                    end else begin
                        phase_q <= phase_q + 4'h1;
                    end
                    if (rx_bit_in != prev_bit_q && phase_q != 4'h0 && phase_q != 4'hf) begin
                        align_q <= 5'h00;
                    end else if (phase_q == 4'hf && align_q != 5'h1f) begin
                        align_q <= align_q + 5'h01;
                    end
                    state_q <= (align_q >= 5'h02) ? sync_locked : sync_hunt;
                end
            endcase
        end
    end

    // fifo decouples mid-bit sampling from the output edge; overflow drops bits
    stream_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in       (clk_in),
        .nrst_in      (nrst_in),
        .clear_in     (!sync_on),
        .wr_data_in   (rx_bit_in),
        .wr_valid_in  (push_bit),
        .wr_ready_out (fifo_ready),
        .rd_data_out  (fifo_bit),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (take_bit)
    );

    // clock high for the first seven of the 16 ticks of a bit, data updated at the rising edge
    // outside sync the pin passes the demodulated level straight through
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            recovered_bit_clock_out <= 1'b0;
            serial_data_pin_out     <= 1'b0;
            serial_data_pin_oe_out  <= 1'b0;
        end else begin
            serial_data_pin_oe_out <= rx_ctrl_q[`RX_MODE_MSB:`RX_MODE_LSB] == `RX_MODE_RECEIVE;
            if (!sync_on) begin
                recovered_bit_clock_out <= 1'b0;
                serial_data_pin_out     <= rx_bit_in;
            end else if (sync_tick) begin
                recovered_bit_clock_out <= phase_q[3] == 1'b0 ? phase_q != 4'h7 : 1'b0;
                if (take_bit && fifo_valid) begin
                    serial_data_pin_out <= fifo_bit;
                end
            end
        end
    end
endmodule : rx_freq_error_and_bit_sync

`default_nettype wire

// ===== rx_freq_error_and_bit_sync_test.sv
// bench of the receive back end: registers, estimator, synchronizer
// assumes the design, its bound checker and the controller model
`default_nettype none
module rx_freq_error_and_bit_sync_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] PAT = 8'hb2;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [6:0]  addr = 7'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        up_p = 1'b0;
    logic        down_p = 1'b0;
    logic        rx_bit = 1'b0;
    logic [7:0]  rdata;
    logic        bclk, sdata, soe, mtick, rtick;
    logic [15:0] win;
    int          cnt, err_count = 0, tests_run = 0;
    int          mod_n = 0, rate_n = 0;
    logic [7:0]  ctl_t [6] = '{8'h01, 8'h02, 8'h07, 8'h0b, 8'h0f, 8'h05};
    int          up_t  [6] = '{20, 20, 5, 20, 1, 150};
    int          dn_t  [6] = '{6, 6, 25, 6, 2, 0};
    logic [7:0]  exp_t [6] = '{8'h14, 8'hfa, 8'hec, 8'h0e, 8'hff, 8'h7f};
    rx_freq_error_and_bit_sync i_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .up_pulse_in(up_p),
        .down_pulse_in(down_p), .rx_bit_in(rx_bit), .recovered_bit_clock_out(bclk),
        .serial_data_pin_out(sdata), .serial_data_pin_oe_out(soe),
        .modulator_tick_out(mtick), .rate_tick_out(rtick)
    );
    bit_sampler i_mcu (
        .bit_clock_in(bclk), .data_in(sdata), .oe_in(soe), .window_out(win), .count_out(cnt)
    );
    always #20 clk_in = ~clk_in;
    // counts the divided ticks as they stand before each edge
    always @(posedge clk_in) begin
        if (mtick === 1'b1) mod_n <= mod_n + 1;
        if (rtick === 1'b1) rate_n <= rate_n + 1;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask : reg_wr
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1;
        check(rdata, e);
    endtask : rd_chk
    task automatic pulses(input int u, input int d);
        for (int i = 0; i < u + d; i++) begin
            @(posedge clk_in);
            up_p   <= i < u;
            down_p <= i >= u;
            rx_bit <= i[0];
        end
        @(posedge clk_in);
        up_p   <= 1'b0;
        down_p <= 1'b0;
    endtask : pulses
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8000) @(posedge clk_in);
        err_count++;
        wrap_up;
    end
    initial begin
        logic [15:0] pp;
        logic        hit;
        int          sp, c0, m0, r0;
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd_chk(7'h06, 8'h00);
        rd_chk(7'h07, 8'h01);
        rd_chk(7'h15, 8'h00);
        rd_chk(7'h40, 8'h00);
        reg_wr(7'h06, 8'hff);
        rd_chk(7'h06, 8'h7f);
        reg_wr(7'h07, 8'hff);
        rd_chk(7'h07, 8'hff);
        reg_wr(7'h40, 8'h5a);
        rd_chk(7'h40, 8'h00);
        // one tick a clock keeps a 64-symbol span near a thousand cycles
        reg_wr(7'h06, 8'h1e);
        reg_wr(7'h07, 8'h01);
        reg_wr(7'h00, 8'h02);
        $display("register test done");
        for (int t = 0; t < 6; t++) begin
            sp = 128 << ctl_t[t][3:2];
            reg_wr(7'h15, 8'h00);
            reg_wr(7'h15, ctl_t[t]);
            pulses(up_t[t], dn_t[t]);
            repeat (sp - 32 - up_t[t] - dn_t[t]) @(posedge clk_in);
            if (t > 0) rd_chk(7'h16, exp_t[t - 1]);
            repeat (78) @(posedge clk_in);
            rd_chk(7'h16, exp_t[t]);
            $display("estimator test %0d done", t);
        end
        reg_wr(7'h16, 8'h33);
        rd_chk(7'h16, 8'h7f);
        reg_wr(7'h00, 8'h0a);
        // worst phase offset: data edges land half a bit from the clock
        repeat (8) @(posedge clk_in);
        for (int b = 0; b < 64; b++) begin
            rx_bit <= PAT[7 - b % 8];
            if (b == 24) begin
                c0 = cnt;
                m0 = mod_n;
                r0 = rate_n;
            end
            if (b == 56) check(8'(cnt - c0), 8'h20);
            if (b == 56) check(8'(mod_n - m0), 8'h08);
            if (b == 56) check(8'(rate_n - r0), 8'h04);
            repeat (16) @(posedge clk_in);
        end
        pp = {PAT, PAT};
        hit = 1'b0;
        for (int r = 0; r < 8; r++) hit |= win[7:0] === 8'(pp >> r);
        check({7'h00, hit}, 8'h01);
        reg_wr(7'h00, 8'h08);
        repeat (20) @(posedge clk_in);
        rd_chk(7'h00, 8'h08);
        $display("synchronizer test done");
        wrap_up;
    end
endmodule : rx_freq_error_and_bit_sync_test
`default_nettype wire
